//--- hdl/rtc_pkg.sv
/*
 * constants and types for the real-time clock bus and register bank.
 * assumes a single 125 MHz system clock; all pin inputs arrive synchronous.
 */
package rtc_pkg;

    // ******************************************
    // widths and address map
    // ******************************************
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam int TIME_BYTES = 10;
    // time and alarm byte indexes, equal to their addresses
    localparam int T_SEC = 0;
    localparam int T_SEC_AL = 1;
    localparam int T_MIN = 2;
    localparam int T_MIN_AL = 3;
    localparam int T_HOUR = 4;
    localparam int T_HOUR_AL = 5;
    localparam int T_WDAY = 6;
    localparam int T_DATE = 7;
    localparam int T_MONTH = 8;
    localparam int T_YEAR = 9;
    localparam logic [6:0] OFS_CTRL_A = 7'h0a;
    localparam logic [6:0] OFS_CTRL_B = 7'h0b;
    localparam logic [6:0] OFS_FLAGS = 7'h0c;
    localparam logic [6:0] OFS_CTRL_D = 7'h0d;
    localparam int RAM_FIRST = 14;
    localparam int RAM_LAST = 127;

    // ******************************************
    // field positions and reset values
    // ******************************************
    localparam int TOP_BIT = 7;
    localparam logic [1:0] ALARM_ANY = 2'h3;
    localparam logic [7:0] CTRL_A_RST = 8'h00;
    localparam logic [7:0] CTRL_B_RST = 8'h00;
    localparam logic [7:0] LOW7_MASK = 8'h7f;

    // ******************************************
    // counting limits, binary values
    // ******************************************
    localparam logic [7:0] SEC_MAX = 8'h3b;
    localparam logic [7:0] HR24_MAX = 8'h17;
    localparam logic [7:0] HR12_TOP = 8'h0c;
    localparam logic [7:0] HR12_PRE = 8'h0b;
    localparam logic [7:0] WDAY_MAX = 8'h07;
    localparam logic [7:0] MONTH_MAX = 8'h0c;
    localparam logic [7:0] YEAR_MAX = 8'h63;
    localparam logic [7:0] DAYS_LONG = 8'h1f;
    localparam logic [7:0] DAYS_SHORT = 8'h1e;
    localparam logic [7:0] DAYS_FEB = 8'h1c;
    localparam logic [7:0] DAYS_FEB_LEAP = 8'h1d;

    // ******************************************
    // types
    // ******************************************
    typedef struct packed {
        logic periodic_flag;
        logic alarm_flag;
        logic update_done_flag;
    } rtc_flags_s;

    typedef struct packed {
        logic freeze;
        logic periodic_irq_enable;
        logic alarm_irq_enable;
        logic update_irq_enable;
        logic square_out_enable;
        logic binary_format_select;
        logic hour24_select;
        logic dst_enable;
    } rtc_ctrl_b_s;

    typedef enum logic [0:0] {
        RTC_BUS_IDLE = 1'b0,
        RTC_BUS_READ = 1'b1
    } rtc_bus_e;

endpackage

//--- hdl/rtc_bus_regs.sv
/*
 * multiplexed address/data bus slave plus time, calendar, alarm,
 * control and user-ram bytes of a real-time clock.
 * assumes the divider chain outside delivers a one-cycle second tick and
 * periodic tick, and that all pins are already synchronous to clk_sys.
 */
`timescale 1ns/1ps

module rtc_bus_regs #(
    parameter int ADDR_BITS = rtc_pkg::ADDR_W,
    parameter int DATA_BITS = rtc_pkg::DATA_W
) (
    input  wire logic                 clk_sys,
    input  wire logic                 reset_n,
    input  wire logic                 pin_reset_n,
    input  wire logic                 supply_good,
    input  wire logic                 bus_style_select,
    input  wire logic                 chip_select_n,
    input  wire logic                 address_latch_strobe,
    input  wire logic                 data_strobe_pin,
    input  wire logic                 direction_pin,
    input  wire logic [7:0]           muxed_addr_data_in,
    output logic      [7:0]           muxed_addr_data_out,
    output logic                      muxed_addr_data_oe_n,
    output logic                      irq_pin_out,
    output logic                      irq_pin_oe_n,
    input  wire logic                 ram_enable_in_n,
    output logic                      ram_enable_out_n,
    input  wire logic                 second_tick,
    input  wire logic                 periodic_tick,
    input  wire logic                 update_in_progress,
    output logic                      square_out_enable,
    output logic      [6:0]           divider_control,
    output rtc_pkg::rtc_flags_s       flags_now
);
    import rtc_pkg::*;

    // ******************************************
    // elaboration checks
    // ******************************************
    // the address map and byte lanes are fixed; other widths cannot be served
    generate
        if (ADDR_BITS != ADDR_W || DATA_BITS != DATA_W) begin : g_bad_width
            $error("rtc_bus_regs supports only 7 address and 8 data bits");
        end
    endgenerate

    // ******************************************
    // storage and state
    // ******************************************
    logic [7:0]  tm [TIME_BYTES];           // internal, always counting
    logic [7:0]  ut [TIME_BYTES];           // software-visible copy
    logic [7:0]  ram [RAM_FIRST:RAM_LAST];
    logic [6:0]  addr;
    logic [7:0]  din_q;
    logic        als_q;
    logic        dstb_q;
    logic        dir_q;
    rtc_bus_e    bus_st;
    logic [7:0]  rd_data;
    logic [7:0]  rd_mux;
    logic [6:0]  ctrl_a;
    rtc_ctrl_b_s ctrl_b;
    rtc_flags_s  flags;
    rtc_flags_s  enables;
    logic        upd_q;
    logic        pin_clear;
    logic        acc_ok;
    logic        read_act;
    logic        read_end;
    logic        write_ev;
    logic        irq_any;
    logic        alarm_hit;
    logic [7:0]  wval;
    logic [7:0]  next_tm [TIME_BYTES];

    // ******************************************
    // format helpers
    // ******************************************
    function automatic logic [7:0] to_bin(input logic [7:0] v, input logic bcd);
        to_bin = bcd ? 8'({4'h0, v[7:4]} * 8'd10 + {4'h0, v[3:0]}) : v;
    endfunction

    function automatic logic [7:0] from_bin(input logic [7:0] v, input logic bcd);
        from_bin = bcd ? {4'(v / 8'd10), 4'(v % 8'd10)} : v;
    endfunction

    // month length in binary; every fourth year is a leap year
    function automatic logic [7:0] month_days(input logic [7:0] mo, input logic [7:0] yr);
        case (mo)
            8'h02:                      month_days = (yr[1:0] == 2'h0) ? DAYS_FEB_LEAP : DAYS_FEB;
            8'h04, 8'h06, 8'h09, 8'h0b: month_days = DAYS_SHORT;
            default:                    month_days = DAYS_LONG;
        endcase
    endfunction

    function automatic logic alarm_match(input logic [7:0] al, input logic [7:0] t);
        alarm_match = (al[7:6] == ALARM_ANY) || (al == t);
    endfunction

    // ******************************************
    // access qualification
    // ******************************************
    // low supply and the reset pin both act as a forced deselect
    assign acc_ok    = ~chip_select_n & supply_good & pin_reset_n;
    assign pin_clear = ~pin_reset_n & supply_good;

    // read window depends on the bus style chosen by the select pin
    assign read_act = acc_ok & (bus_style_select ? (data_strobe_pin & direction_pin)
                                                 : ~data_strobe_pin);
    assign read_end = (bus_st == RTC_BUS_READ) & ~read_act;

    // writes land on the trailing edge of the strobe, using data sampled before it
    assign write_ev = acc_ok & (bus_style_select ? (dstb_q & ~data_strobe_pin & ~dir_q)
                                                 : (~dir_q & direction_pin));
    assign wval = (addr == 7'(T_SEC)) ? (din_q & LOW7_MASK) : din_q;

    // ******************************************
    // pin sampling and address latch
    // ******************************************
    // address is taken even with chip select high
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            als_q  <= 1'b0;
            dstb_q <= 1'b0;
            dir_q  <= 1'b1;
            din_q  <= 8'h00;
            addr   <= 7'h00;
        end else begin
            als_q  <= address_latch_strobe;
            dstb_q <= data_strobe_pin;
            dir_q  <= direction_pin;
            din_q  <= muxed_addr_data_in;
            if (als_q && !address_latch_strobe) begin
                addr <= din_q[6:0];
            end
        end
    end

    // ******************************************
    // read data path
    // ******************************************
    // read source, the flag byte carries the summary bit on top
    always_comb begin
        if (addr < 7'(TIME_BYTES)) begin
            rd_mux = ut[addr[3:0]];
        end else begin
            case (addr)
                OFS_CTRL_A: rd_mux = {update_in_progress, ctrl_a};
                OFS_CTRL_B: rd_mux = ctrl_b;
                OFS_FLAGS:  rd_mux = {irq_any, flags, 4'h0};
                OFS_CTRL_D: rd_mux = {supply_good, 7'h00};
                default:    rd_mux = ram[addr];
            endcase
        end
    end

    // data is caught once at the start of the strobe so it stays stable
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            bus_st  <= RTC_BUS_IDLE;
            rd_data <= 8'h00;
        end else begin
            case (bus_st)
                RTC_BUS_IDLE: begin
                    if (read_act) begin
                        bus_st  <= RTC_BUS_READ;
                        rd_data <= rd_mux;
                    end
                end
                RTC_BUS_READ: begin
                    if (!read_act) begin
                        bus_st <= RTC_BUS_IDLE;
                    end
                end
                default: bus_st <= RTC_BUS_IDLE;
            endcase
        end
    end

    // drive only while the read window is open and data has been caught
    assign muxed_addr_data_out  = rd_data;
    assign muxed_addr_data_oe_n = ~((bus_st == RTC_BUS_READ) & read_act);

    // ******************************************
    // control registers
    // ******************************************
    // flag register and control D ignore writes, control A top bit is status
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            ctrl_a <= CTRL_A_RST[6:0];
            ctrl_b <= CTRL_B_RST;
        end else begin
            if (write_ev && addr == OFS_CTRL_A) begin
                ctrl_a <= din_q[6:0];
            end
            if (write_ev && addr == OFS_CTRL_B) begin
                ctrl_b <= din_q;
            end
            if (pin_clear) begin
                ctrl_b.periodic_irq_enable <= 1'b0;
                ctrl_b.alarm_irq_enable    <= 1'b0;
                ctrl_b.update_irq_enable   <= 1'b0;
                ctrl_b.square_out_enable   <= 1'b0;
            end
        end
    end

    assign square_out_enable = ctrl_b.square_out_enable;
    assign divider_control   = ctrl_a;

    // ******************************************
    // interrupt flags
    // ******************************************
    assign enables = '{periodic_flag:    ctrl_b.periodic_irq_enable,
                       alarm_flag:       ctrl_b.alarm_irq_enable,
                       update_done_flag: ctrl_b.update_irq_enable};
    assign irq_any = |(flags & enables);

    assign alarm_hit = alarm_match(tm[T_SEC_AL], tm[T_SEC])
                     & alarm_match(tm[T_MIN_AL], tm[T_MIN])
                     & alarm_match(tm[T_HOUR_AL], tm[T_HOUR]);

    // a flag read clears only what it showed; new events win over the clear
    always_ff @(posedge clk_sys) begin
        if (!reset_n || pin_clear) begin
            flags <= '0;
        end else begin
            if (read_end && addr == OFS_FLAGS) begin
                flags <= flags & ~rd_data[6:4];
            end
            if (periodic_tick) begin
                flags.periodic_flag <= 1'b1;
            end
            if (upd_q) begin
                flags.update_done_flag <= 1'b1;
                if (alarm_hit) begin
                    flags.alarm_flag <= 1'b1;
                end
            end
        end
    end

    // open drain: the level is always low, only the enable moves
    assign irq_pin_out  = 1'b0;
    assign irq_pin_oe_n = ~irq_any;
    assign flags_now    = flags;

    // external ram enable passes through only with good supply and no reset
    assign ram_enable_out_n = (supply_good & pin_reset_n) ? ram_enable_in_n : 1'b1;

    // ******************************************
    // next second, computed in binary
    // ******************************************
    // bcd bytes are converted in and out so one set of limits serves both
    always_comb begin
        logic       bcd;
        logic       pm;
        logic       carry;
        logic [7:0] s;
        logic [7:0] mi;
        logic [7:0] h;
        logic [7:0] wd;
        logic [7:0] dt;
        logic [7:0] mo;
        logic [7:0] yr;
        bcd   = ~ctrl_b.binary_format_select;
        pm    = tm[T_HOUR][TOP_BIT];
        s     = to_bin(tm[T_SEC] & LOW7_MASK, bcd);
        mi    = to_bin(tm[T_MIN], bcd);
        h     = to_bin(tm[T_HOUR] & LOW7_MASK, bcd);
        wd    = to_bin(tm[T_WDAY], bcd);
        dt    = to_bin(tm[T_DATE], bcd);
        mo    = to_bin(tm[T_MONTH], bcd);
        yr    = to_bin(tm[T_YEAR], bcd);
        carry = 1'b0;
        for (int i = 0; i < TIME_BYTES; i++) begin
            next_tm[i] = tm[i];
        end
        // seconds and minutes
        if (s >= SEC_MAX) begin
            s     = 8'h00;
            carry = 1'b1;
        end else begin
            s = s + 8'h01;
        end
        if (carry) begin
            carry = 1'b0;
            if (mi >= SEC_MAX) begin
                mi    = 8'h00;
                carry = 1'b1;
            end else begin
                mi = mi + 8'h01;
            end
        end
        // hours, day carry leaves at midnight in either format
        if (carry) begin
            carry = 1'b0;
            if (ctrl_b.hour24_select) begin
                if (h >= HR24_MAX) begin
                    h     = 8'h00;
                    carry = 1'b1;
                end else begin
                    h = h + 8'h01;
                end
            end else if (h >= HR12_TOP) begin
                h = 8'h01;
            end else if (h == HR12_PRE) begin
                h     = HR12_TOP;
                carry = pm;
                pm    = ~pm;
            end else begin
                h = h + 8'h01;
            end
        end
        // calendar
        if (carry) begin
            wd = (wd >= WDAY_MAX) ? 8'h01 : wd + 8'h01;
            if (dt >= month_days(mo, yr)) begin
                dt = 8'h01;
                if (mo >= MONTH_MAX) begin
                    mo = 8'h01;
                    yr = (yr >= YEAR_MAX) ? 8'h00 : yr + 8'h01;
                end else begin
                    mo = mo + 8'h01;
                end
            end else begin
                dt = dt + 8'h01;
            end
        end
        next_tm[T_SEC]   = from_bin(s, bcd);
        next_tm[T_MIN]   = from_bin(mi, bcd);
        // pm rides on top; no hour value reaches bit seven in either format
        next_tm[T_HOUR]  = from_bin(h, bcd) | {pm & ~ctrl_b.hour24_select, 7'h00};
        next_tm[T_WDAY]  = from_bin(wd, bcd);
        next_tm[T_DATE]  = from_bin(dt, bcd);
        next_tm[T_MONTH] = from_bin(mo, bcd);
        next_tm[T_YEAR]  = from_bin(yr, bcd);
    end

    // ******************************************
    // time bytes
    // ******************************************
    // update marker one cycle after the tick, when the new time is in place
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            upd_q <= 1'b0;
        end else begin
            upd_q <= second_tick;
        end
    end

    // not reset: time survives both resets; a write overrides a same-cycle step
    always_ff @(posedge clk_sys) begin
        if (second_tick) begin
            for (int i = 0; i < TIME_BYTES; i++) begin
                tm[i] <= next_tm[i];
            end
        end
        if (upd_q && !ctrl_b.freeze) begin
            for (int i = 0; i < TIME_BYTES; i++) begin
                ut[i] <= tm[i];
            end
        end
        if (write_ev && addr < 7'(TIME_BYTES)) begin
            tm[addr[3:0]] <= wval;
            ut[addr[3:0]] <= wval;
        end
    end

    // ******************************************
    // general-purpose ram
    // ******************************************
    // not reset, the contents are meant to outlive a reset
    always_ff @(posedge clk_sys) begin
        if (write_ev && addr >= 7'(RAM_FIRST)) begin
            ram[addr] <= din_q;
        end
    end

endmodule

//--- verif/rtc_props.sv
/* checker for the rtc bus and register block, watching its ports only.
   assumes a bind from the bench top and one clock domain on clk_sys. */
`timescale 1ns/1ps
module rtc_props
    import rtc_pkg::*;
(
    input wire logic                clk_sys,
    input wire logic                reset_n,
    input wire logic                pin_reset_n,
    input wire logic                supply_good,
    input wire logic                bus_style_select,
    input wire logic                chip_select_n,
    input wire logic                data_strobe_pin,
    input wire logic                direction_pin,
    input wire logic                muxed_addr_data_oe_n,
    input wire logic                irq_pin_oe_n,
    input wire logic                irq_pin_out,
    input wire logic                ram_enable_in_n,
    input wire logic                ram_enable_out_n,
    input wire logic                second_tick,
    input wire logic                periodic_tick,
    input wire logic                square_out_enable,
    input wire logic [6:0]          divider_control,
    input wire rtc_pkg::rtc_flags_s flags_now
);
    // ****
    // qualified read window and properties
    // ****
    logic rd_win;
    assign rd_win = !chip_select_n && supply_good && pin_reset_n &&
                    (bus_style_select ? (data_strobe_pin && direction_pin) : !data_strobe_pin);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    irq_cause_a: assert property (!irq_pin_oe_n |-> flags_now != 3'h0)
        else $error("irq line pulled with no flag set");
    irq_level_a: assert property (irq_pin_out == 1'b0)
        else $error("irq line level not low");
    pin_rst_a: assert property ($past(!pin_reset_n && supply_good) && !pin_reset_n |->
        flags_now == 3'h0 && irq_pin_oe_n && !square_out_enable) else $error("pin reset left state");
    ram_gate_a: assert property (ram_enable_out_n == (ram_enable_in_n | !supply_good | !pin_reset_n))
        else $error("ram enable out wrong");
    rd_rel_a: assert property (!rd_win |-> muxed_addr_data_oe_n)
        else $error("bus driven outside read window");
    rd_drv_a: assert property (rd_win && $past(rd_win) |-> !muxed_addr_data_oe_n)
        else $error("bus not driven in read window");
    upd_flag_a: assert property (second_tick ##1 pin_reset_n |=> flags_now.update_done_flag)
        else $error("update flag not set after second");
    per_flag_a: assert property (periodic_tick && pin_reset_n ##1 pin_reset_n |-> ##[0:1]
        flags_now.periodic_flag) else $error("periodic flag not set");
    ctl_hold_a: assert property (chip_select_n || !pin_reset_n |=> $stable(divider_control))
        else $error("control a changed without access");
endmodule

//--- verif/rtc_host.sv
/* host processor model on the multiplexed address/data pins.
   assumes the bench picks the bus style and calls acc; the bus has no pull. */
`timescale 1ns/1ps
module rtc_host (
    input  wire logic       clk_sys,
    input  wire logic       style,
    input  wire logic [7:0] dut_out,
    input  wire logic       dut_oe_n,
    output logic            chip_select_n,
    output logic            address_latch_strobe,
    output logic            data_strobe_pin,
    output logic            direction_pin,
    output logic [7:0]      bus_level
);
    // ****
    // bus level and one access
    // ****
    logic       drive = 1'b0;
    logic [7:0] hd = 8'h00;
    logic [7:0] last = 8'h00;
    initial begin
        chip_select_n = 1'b1;
        address_latch_strobe = 1'b0;
        data_strobe_pin = 1'b1;
        direction_pin = 1'b1;
    end
    // released bus shows the inverse of its last level, so stale data never matches
    always_ff @(posedge clk_sys) last <= bus_level;
    assign bus_level = !dut_oe_n ? dut_out : (drive ? hd : ~last);
    // one byte access; read data taken at a rising edge inside the strobe
    task automatic acc(input logic wr, input logic cs, input logic [6:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        @(negedge clk_sys);
        data_strobe_pin = !style;
        address_latch_strobe = 1'b1;
        hd = {1'b0, a};
        drive = 1'b1;
        @(negedge clk_sys);
        address_latch_strobe = 1'b0;
        @(negedge clk_sys);
        chip_select_n = cs;
        hd = d;
        drive = wr;
        if (style) begin
            direction_pin = !wr;
            data_strobe_pin = 1'b1;
        end else if (wr) direction_pin = 1'b0;
        else data_strobe_pin = 1'b0;
        repeat (3) @(posedge clk_sys);
        q = bus_level;
        @(negedge clk_sys);
        data_strobe_pin = !style;
        direction_pin = 1'b1;
        @(negedge clk_sys);
        chip_select_n = 1'b1;
        drive = 1'b0;
    endtask
endmodule

//--- verif/tb_top.sv
/* bench for the rtc bus block: host model, scenarios and verdict.
   assumes 125 MHz clk_sys; second and periodic ticks come from the bench. */
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_count++; \
    $display("Error %s exp %h got %h", n, e, g); end end
module tb_top;
    import rtc_pkg::*;
    // ****
    // stimulus, instances, scenarios
    // ****
    logic       clk_sys = 0, reset_n = 0, pin_reset_n = 1, supply_good = 1, style = 0;
    logic       ram_in_n = 0, sec_tick = 0, per_tick = 0, uip = 0;
    logic       cs_n, als, ds, dir, oe_n, irq_oe_n, ram_out_n, sqw;
    logic [7:0] dout, bus, q;
    logic [6:0] divc;
    rtc_flags_s flg;
    int         err_count = 0, compares = 0, cyc = 0;
    initial forever #4 clk_sys = ~clk_sys;
    rtc_host h (.clk_sys(clk_sys), .style(style), .dut_out(dout), .dut_oe_n(oe_n), .chip_select_n(cs_n),
        .address_latch_strobe(als), .data_strobe_pin(ds), .direction_pin(dir), .bus_level(bus));
    rtc_bus_regs dut (.clk_sys(clk_sys), .reset_n(reset_n), .pin_reset_n(pin_reset_n),
        .supply_good(supply_good), .bus_style_select(style), .chip_select_n(cs_n),
        .address_latch_strobe(als), .data_strobe_pin(ds), .direction_pin(dir), .muxed_addr_data_in(bus),
        .muxed_addr_data_out(dout), .muxed_addr_data_oe_n(oe_n), .irq_pin_out(), .irq_pin_oe_n(irq_oe_n),
        .ram_enable_in_n(ram_in_n), .ram_enable_out_n(ram_out_n), .second_tick(sec_tick),
        .periodic_tick(per_tick), .update_in_progress(uip), .square_out_enable(sqw),
        .divider_control(divc), .flags_now(flg));
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        h.acc(1'b1, 1'b0, a, d, q);
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        h.acc(1'b0, 1'b0, a, 8'h00, q);
        `CHK($sformatf("addr %h", a), e, q)
    endtask
    // one-cycle pulse, then time for the visible copy and flags to settle
    task automatic pulse(input logic per);
        @(negedge clk_sys);
        if (per) per_tick = 1'b1;
        else sec_tick = 1'b1;
        @(negedge clk_sys);
        per_tick = 1'b0;
        sec_tick = 1'b0;
        repeat (3) @(negedge clk_sys);
    endtask
    // both bus styles: ram, read-only bits, control a
    task automatic t_bus;
        for (int s = 0; s < 2; s++) begin
            @(negedge clk_sys);
            style = s[0];
            wr(7'h0e, 8'ha5 + 8'(s));
            wr(7'h7f, 8'h3c);
            rd(7'h0e, 8'ha5 + 8'(s));
            rd(7'h7f, 8'h3c);
            wr(7'h00, 8'hff);
            rd(7'h00, 8'h7f);
            wr(7'h0d, 8'h55);
            rd(7'h0d, 8'h80);
            wr(7'h0a, 8'h8a);
            rd(7'h0a, 8'h0a);
            `CHK("divider", 7'h0a, divc)
        end
    endtask
    // deselected and low-supply cycles must not write
    task automatic t_desel;
        `CHK("ram out", 1'b0, ram_out_n)
        h.acc(1'b1, 1'b1, 7'h0e, 8'h00, q);
        rd(7'h0e, 8'ha6);
        supply_good = 1'b0;
        @(negedge clk_sys);
        `CHK("ram out", 1'b1, ram_out_n)
        wr(7'h0e, 8'h00);
        supply_good = 1'b1;
        rd(7'h0e, 8'ha6);
    endtask
    // alarm wildcard, flags, irq, flag read, pin reset
    task automatic t_irq;
        wr(7'h01, 8'hc0);
        wr(7'h03, 8'hc0);
        wr(7'h05, 8'hff);
        wr(7'h0b, 8'h3e);
        pulse(1'b0);
        `CHK("flags", 3'b011, flg)
        `CHK("irq", 1'b0, irq_oe_n)
        rd(7'h0c, 8'hb0);
        `CHK("flags", 3'b000, flg)
        `CHK("irq", 1'b1, irq_oe_n)
        pulse(1'b1);
        `CHK("flags", 3'b100, flg)
        pin_reset_n = 1'b0;
        @(negedge clk_sys);
        `CHK("flags", 3'b000, flg)
        `CHK("sqw", 1'b0, sqw)
        `CHK("ram out", 1'b1, ram_out_n)
        wr(7'h0b, 8'hff);
        pin_reset_n = 1'b1;
        rd(7'h0b, 8'h06);
    endtask
    // leap-day rollover, bcd 12-hour step, freeze
    task automatic t_time;
        logic [6:0] ta[7] = '{7'h0, 7'h2, 7'h4, 7'h6, 7'h7, 7'h8, 7'h9};
        logic [7:0] tv[7] = '{8'h3b, 8'h3b, 8'h17, 8'h07, 8'h1d, 8'h02, 8'h04};
        logic [7:0] te[7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h03, 8'h04};
        wr(7'h0b, 8'h86);
        for (int i = 0; i < 7; i++) wr(ta[i], tv[i]);
        wr(7'h0b, 8'h06);
        pulse(1'b0);
        for (int i = 0; i < 7; i++) rd(ta[i], te[i]);
        wr(7'h0b, 8'h80);
        wr(7'h04, 8'h11);
        wr(7'h02, 8'h59);
        wr(7'h00, 8'h59);
        wr(7'h0b, 8'h00);
        pulse(1'b0);
        rd(7'h04, 8'h92);
        wr(7'h0b, 8'h80);
        pulse(1'b0);
        rd(7'h00, 8'h00);
        wr(7'h0b, 8'h00);
        pulse(1'b0);
        rd(7'h00, 8'h02);
    endtask
    task automatic wrap_up;
        if (err_count == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // hang guard, far above the few hundred cycles the scenarios need
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            wrap_up();
        end
    end
    initial begin
        repeat (8) @(negedge clk_sys);
        reset_n = 1'b1;
        t_bus();
        t_desel();
        t_irq();
        t_time();
        wrap_up();
    end
endmodule
bind rtc_bus_regs rtc_props chk (.clk_sys(clk_sys), .reset_n(reset_n), .pin_reset_n(pin_reset_n),
    .supply_good(supply_good), .bus_style_select(bus_style_select), .chip_select_n(chip_select_n),
    .data_strobe_pin(data_strobe_pin), .direction_pin(direction_pin), .irq_pin_oe_n(irq_pin_oe_n),
    .irq_pin_out(irq_pin_out),
    .muxed_addr_data_oe_n(muxed_addr_data_oe_n), .ram_enable_in_n(ram_enable_in_n),
    .ram_enable_out_n(ram_enable_out_n), .second_tick(second_tick), .periodic_tick(periodic_tick),
    .square_out_enable(square_out_enable), .divider_control(divider_control), .flags_now(flags_now));
